/* File: common/adc_readout_consts.svh */
// Constants shared by the ADC result read-out logic
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH
// Channel and word layout
`define ADC_CHANNELS         8
`define ADC_CODE_BITS        14
`define ADC_WORD_BITS        16
`define ADC_PAD_BITS         2
`define ADC_GROUP_FLIP       3'h4
`define ADC_ACC_BITS         20
// Oversampling codes
`define ADC_OS_BITS          3
`define ADC_OS_MAX_CODE      3'h6
`define ADC_RATIO_RESET      3'h0
// Serial frame length per channel, in clocks
`define ADC_SERIAL_FRAME_DEF 14
// Byte mode strobes that hold the marker high
`define ADC_MARK_STROBES     4'h2
// Positions in the synchronised pin vector
`define PIN_CSB              0
`define PIN_RDB              1
`define PIN_SCLK             2
`define PIN_IFSEL            3
`define PIN_WIDESEL          4
`define PIN_ORDER            5
`define PIN_START1           6
`define PIN_START2           7
`define PIN_OS_LO            8
`define PIN_COUNT            11
`endif

/* File: common/adc_readout_pkg.sv */
// Types shared by the ADC result read-out logic
`include "adc_readout_consts.svh"
package adc_readout_pkg;
  typedef logic [`ADC_WORD_BITS-1:0]                 result_word_t;
  typedef logic [`ADC_CHANNELS*`ADC_CODE_BITS-1:0]   sample_bus_t;
  typedef logic [`ADC_OS_BITS-1:0]                   os_code_t;
  // Conversion sequencer, Gray along idle -> convert -> load
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONV = 2'b01,
    SEQ_LOAD = 2'b11
  } seq_state_t;
  // Read mode from {interface select, wide/byte select}
  typedef enum logic [1:0] {
    MODE_WORD   = 2'b00,
    MODE_UNUSED = 2'b01,
    MODE_SERIAL = 2'b10,
    MODE_BYTE   = 2'b11
  } read_mode_t;
endpackage

/* File: common/avg_if.sv */
// Link between the conversion sequencer and the averaging filter
`timescale 1ns/10ps
`default_nettype none
interface avg_if;
  import adc_readout_pkg::*;
  logic        ce;          // Clock enable
  logic        clear;       // Drop partial sums
  logic        sampleValid; // One raw sample set
  os_code_t    ratio;       // Log2 of sample count
  sample_bus_t sample;      // Raw samples, channel 0 low
  logic        done;        // Average ready, one cycle
  sample_bus_t average;     // Averaged samples
  modport seq (output ce, clear, sampleValid, ratio, sample, input done, average);
  modport avg (input ce, clear, sampleValid, ratio, sample, output done, average);
endinterface
`default_nettype wire

/* File: tb/adc_core_model.sv */
// Converter core stand-in: one sample set per request, after a delay
`timescale 1ns/10ps
`default_nettype none
module adc_core_model
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_b,
  // Request and answer
  input  wire logic   convReq,
  output logic        adcDone,
  output sample_bus_t adcData
);
  logic [7:0] waitCnt; // Cycles left of the conversion
  logic [4:0] setNum;  // Sets delivered, shapes the data
  // Slow answer so reads fit while busy; one done per request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 8'h00;
      setNum  <= 5'h00;
      adcDone <= 1'b0;
    end else begin
      adcDone <= (waitCnt == 8'h01);
      if (convReq) waitCnt <= 8'h3c;
      else if (waitCnt != 8'h00) waitCnt <= waitCnt - 8'h01;
      if (adcDone) setNum <= setNum + 5'h01;
    end
  end
  // Channel c carries (c+1)*256 + 2*set, so averages are easy to predict
  always_comb begin
    for (int c = 0; c < 8; c++) adcData[c*14 +: 14] = 14'((c + 1) * 256 + 2 * setNum);
  end
endmodule
`default_nettype wire

/* File: tb/adc_result_readout_port_tb.sv */
// Self-checking bench for the result read-out port
`timescale 1ns/10ps
`default_nettype none
module adc_result_readout_port_tb;
  import adc_readout_pkg::*;
  logic        clk, rst_b, csB, rdB, sclk, ifSel, wideSel, order, st1, st2, convReq, adcDone;
  logic        busy, byteOe, serA, serB, serOe, mark, markOe;
  logic [2:0]  osIn;
  os_code_t    osUsed;
  logic [7:0]  byteBus;
  sample_bus_t adcData;
  logic [13:0] shA, shB, v;
  int          bad_count, num_checks, cyc, len0, len1;
  adc_result_readout_port dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .chipSelectB(csB),
    .readStrobeB(rdB), .serialClk(sclk), .interfaceSelectInput(ifSel),
    .wideOrByteSelectInput(wideSel), .byteOrderInput(order), .startGroupOne(st1),
    .startGroupTwo(st2), .oversampleRatioInputs(osIn), .adcDone(adcDone), .adcData(adcData),
    .convReq(convReq), .busy(busy), .byteOutputBus(byteBus), .byteOutputBusOe(byteOe),
    .serialOutPrimary(serA), .serialOutSecondary(serB), .serialOutOe(serOe),
    .firstChannelMarker(mark), .firstChannelMarkerOe(markOe), .oversampleRatio(osUsed));
  adc_core_model core (.clk(clk), .rst_b(rst_b), .convReq(convReq), .adcDone(adcDone),
    .adcData(adcData));
  // Expected code of channel c (0-based) for sample set n
  function automatic logic [13:0] val(input int c, input int n);
    return 14'((c + 1) * 256 + 2 * n);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Both starts together, then wait for busy to rise
  task automatic startConv();
    st1 = 1'b1;
    st2 = 1'b1;
    wc(4);
    st1 = 1'b0;
    st2 = 1'b0;
    while (busy !== 1'b1) wc(1);
  endtask
  task automatic waitIdle(output int len);
    len = 0;
    while (busy === 1'b1) begin
      wc(1);
      len++;
    end
  endtask
  // One strobe, then check byte and marker
  task automatic strobe(input logic [7:0] exp, input logic expMark);
    rdB = 1'b0;
    wc(6);
    chk(byteBus, exp);
    chk(mark, expMark);
    rdB = 1'b1;
    wc(6);
  endtask
  // nch channels of 14 clocks in one select; clock idles high, bits taken before each rise
  task automatic serFrame(input logic [13:0] expA, input logic [13:0] expB, input logic m,
                          input int nch);
    csB = 1'b0;
    wc(6);
    chk({serOe, markOe, mark}, {2'b11, m});
    for (int c = 0; c < nch; c++) begin
      for (int k = 0; k < 14; k++) begin
        sclk = 1'b0;
        wc(4);
        shA = {shA[12:0], serA};
        shB = {shB[12:0], serB};
        sclk = 1'b1;
        wc(4);
      end
      chk(shA, expA + 14'(c * 256));
      chk(shB, expB + 14'(c * 256));
    end
    chk(mark, 1'b0);
    csB = 1'b1;
    wc(6);
    chk({serOe, markOe}, 2'b00);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {csB, rdB, sclk, ifSel, wideSel, order} = 6'h3f;
    {st1, st2, rst_b} = 3'h0;
    osIn = 3'h1;
    wc(3);
    rst_b = 1'b1;
    wc(4);
    startConv();
    waitIdle(len0);
    chk(osUsed, 3'h1);
    // Byte mode, upper first, channels 1 and 2
    csB = 1'b0;
    wc(6);
    chk({byteOe, markOe, mark}, 3'h6);
    for (int i = 0; i < 4; i++) begin
      v = val(i / 2, 0);
      strobe(i % 2 ? {v[5:0], 2'b00} : v[13:6], i < 2);
    end
    csB = 1'b1;
    wc(6);
    chk({byteOe, markOe}, 2'b00);
    // Serial mode, one frame per channel, stray clocks while deselected
    wideSel = 1'b0;
    wc(4);
    serFrame(val(0, 0), val(4, 0), 1'b1, 1);
    repeat (6) begin
      sclk = ~sclk;
      wc(4);
    end
    serFrame(val(1, 0), val(5, 0), 1'b0, 1);
    // Averaged conversion, read during busy in byte mode, lower first
    osIn = 3'h0;
    wideSel = 1'b1;
    order = 1'b0;
    startConv();
    csB = 1'b0;
    wc(6);
    v = val(0, 0);
    strobe({v[5:0], 2'b00}, 1'b1);
    strobe(v[13:6], 1'b1);
    csB = 1'b1;
    waitIdle(len1);
    chk(16'(len1 > len0), 16'h1);
    chk(osUsed, 3'h0);
    wideSel = 1'b0;
    wc(4);
    serFrame(val(0, 0) + 14'h3, val(4, 0) + 14'h3, 1'b1, 4);
    end_sim();
  end
endmodule
`default_nettype wire

/* File: verilog/adc_result_readout_port.sv */
// Result read-out port: byte and serial read modes, sequencer, averaging
//
// How it works
// RL1 - Results are 14-bit code plus two zeros
// RL2 - Both selects high picks byte mode
// RL3 - Byte order input picks upper or lower first
// RL4 - Chip select enables bus; strobes step bytes
// RL5 - Marker high two strobes, low at third
// RL6 - Interface high, wide low picks serial mode
// RL7 - Chip select high: outputs off, clock ignored
// RL8 - Chip select fall drives MSB out
// RL9 - Later bits shift on clock rise
// RL10 - Host may frame per channel or whole read
// RL11 - Primary sends 1-4 then 5-8; secondary reversed
// RL12 - Serial marker high at channel 1, low at 14th fall
// RL13 - Marker also covers channel 5 on secondary
// RL14 - Host gives 112 or 56 serial clocks
// RL15 - Reads during busy return previous results
// RL16 - Host ends reads before busy falls
// RL17 - Ratio inputs latched on busy fall
// RL18 - Host drives both starts together when oversampling
// RL19 - Busy lasts longer with higher ratio
// RL20 - Oversampled results pass averaging filter
// RL21 - Busy high during conversion; results load at fall
// RL22 - Both selects low picks word mode; here it only turns the byte and serial outputs off
// RL23 - Serial frame length is a parameter, 14
// RL24 - Ratio zero plain; else power-of-two averaging
`timescale 1ns/10ps
`default_nettype none
module adc_result_readout_port
  import adc_readout_pkg::*;
#(
  parameter logic [3:0] SERIAL_FRAME = 4'(`ADC_SERIAL_FRAME_DEF) // [RL23]
) (
  // Clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Host control pins, asynchronous
  input  wire logic       chipSelectB,
  input  wire logic       readStrobeB,
  input  wire logic       serialClk,
  input  wire logic       interfaceSelectInput,
  input  wire logic       wideOrByteSelectInput,
  input  wire logic       byteOrderInput,
  input  wire logic       startGroupOne,
  input  wire logic       startGroupTwo,
  input  wire logic [2:0] oversampleRatioInputs,
  // Converter core, same clock
  input  wire logic       adcDone,
  input  wire sample_bus_t adcData,
  output logic            convReq,
  // Host outputs
  output logic            busy,
  output logic [7:0]      byteOutputBus,
  output logic            byteOutputBusOe,
  output logic            serialOutPrimary,
  output logic            serialOutSecondary,
  output logic            serialOutOe,
  output logic            firstChannelMarker,
  output logic            firstChannelMarkerOe,
  // Status
  output os_code_t        oversampleRatio
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [`PIN_COUNT-1:0] sync1_ff; // First stage, read by sync2 only
  logic [`PIN_COUNT-1:0] sync2_ff; // Safe to use
  logic [`PIN_COUNT-1:0] prev_ff;  // Previous value for edges
  logic [`PIN_COUNT-1:0] pinRaw;

  assign pinRaw = {oversampleRatioInputs, startGroupTwo, startGroupOne, byteOrderInput,
                   wideOrByteSelectInput, interfaceSelectInput, serialClk, readStrobeB,
                   chipSelectB};

  // Two flops then an edge history stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff <= {`PIN_COUNT{1'b1}};
      sync2_ff <= {`PIN_COUNT{1'b1}};
      prev_ff  <= {`PIN_COUNT{1'b1}};
    end else if (ce) begin
      sync1_ff <= pinRaw;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // Edge events, gated by the enable so a frozen cycle sees none
  logic       csLow;
  logic       csFall;
  logic       csRise;
  logic       rdFall;
  logic       sclkRise;
  logic       sclkFall;
  logic       startOneRise;
  logic       startTwoRise;
  os_code_t   osPins;
  read_mode_t mode;

  assign csLow        = ~sync2_ff[`PIN_CSB];
  assign csFall       = ce & prev_ff[`PIN_CSB] & ~sync2_ff[`PIN_CSB];
  assign csRise       = ce & ~prev_ff[`PIN_CSB] & sync2_ff[`PIN_CSB];
  assign rdFall       = ce & prev_ff[`PIN_RDB] & ~sync2_ff[`PIN_RDB];
  assign sclkRise     = ce & ~prev_ff[`PIN_SCLK] & sync2_ff[`PIN_SCLK];
  assign sclkFall     = ce & prev_ff[`PIN_SCLK] & ~sync2_ff[`PIN_SCLK];
  assign startOneRise = ce & ~prev_ff[`PIN_START1] & sync2_ff[`PIN_START1];
  assign startTwoRise = ce & ~prev_ff[`PIN_START2] & sync2_ff[`PIN_START2];
  assign osPins       = sync2_ff[`PIN_OS_LO +: `ADC_OS_BITS];
  assign mode         = read_mode_t'({sync2_ff[`PIN_IFSEL], sync2_ff[`PIN_WIDESEL]}); // [RL2] [RL6]

  // ****************************************
  // Conversion sequencer
  // ****************************************
  avg_if avgBus ();

  seq_state_t   state_ff;                       // Sequencer state
  seq_state_t   nxt_state;
  logic         armOne_ff;                      // Group one sampled
  logic         nxt_armOne;
  logic         armTwo_ff;                      // Group two sampled
  logic         nxt_armTwo;
  logic         busy_ff;
  logic         nxt_busy;
  logic         convReq_ff;
  logic         nxt_convReq;
  os_code_t     ratio_ff;                       // Ratio for the running conversion
  os_code_t     nxt_ratio;
  logic         sampleSeen_ff;                  // Core answered one cycle ago
  logic         nxt_sampleSeen;
  result_word_t results_ff  [`ADC_CHANNELS];   // Output registers
  result_word_t nxt_results [`ADC_CHANNELS];

  assign avgBus.ce          = ce;
  assign avgBus.clear       = (state_ff == SEQ_IDLE);
  assign avgBus.sampleValid = adcDone;
  assign avgBus.sample      = adcData;
  assign avgBus.ratio       = ratio_ff;

  sample_averager u_avg (
    .clk   (clk),
    .rst_b (rst_b),
    .bus   (avgBus)
  );

  // Next state of the sequencer
  always_comb begin
    nxt_state   = state_ff;
    nxt_armOne  = armOne_ff;
    nxt_armTwo  = armTwo_ff;
    nxt_busy    = busy_ff;
    nxt_convReq = 1'b0;
    nxt_ratio   = ratio_ff;
    nxt_results = results_ff;
    nxt_sampleSeen = adcDone;
    unique case (state_ff)
      SEQ_IDLE: begin
        // Groups may be started apart; conversion waits for both
        nxt_armOne = armOne_ff | startOneRise;
        nxt_armTwo = armTwo_ff | startTwoRise;
        if (nxt_armOne && nxt_armTwo) begin
          nxt_state   = SEQ_CONV;
          nxt_busy    = 1'b1;                  // [RL21]
          nxt_convReq = 1'b1;
          nxt_armOne  = 1'b0;
          nxt_armTwo  = 1'b0;
        end
      end
      SEQ_CONV: begin
        // Starts seen while busy are dropped
        // Ask again only after the averager has judged the set; asking on the
        // last sample would start a stray set that nobody averages
        if (avgBus.done) begin
          nxt_state = SEQ_LOAD;
        end else if (sampleSeen_ff) begin
          nxt_convReq = 1'b1;                  // [RL19]
        end
      end
      SEQ_LOAD: begin
        // Refresh results and drop busy in the same edge
        for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
          nxt_results[ch] = {avgBus.average[ch*`ADC_CODE_BITS +: `ADC_CODE_BITS],
                             `ADC_PAD_BITS'(0)}; // [RL1] [RL20] [RL21]
        end
        nxt_busy  = 1'b0;
        nxt_ratio = (osPins > `ADC_OS_MAX_CODE) ? `ADC_RATIO_RESET : osPins; // [RL17] [RL24]
        nxt_state = SEQ_IDLE;
      end
      default: begin
        nxt_state = SEQ_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // Register stage of the sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff   <= SEQ_IDLE;
      armOne_ff  <= 1'b0;
      armTwo_ff  <= 1'b0;
      busy_ff    <= 1'b0;
      convReq_ff <= 1'b0;
      ratio_ff   <= `ADC_RATIO_RESET;
      sampleSeen_ff <= 1'b0;
      for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
        results_ff[ch] <= '0;
      end
    end else if (ce) begin
      state_ff   <= nxt_state;
      armOne_ff  <= nxt_armOne;
      armTwo_ff  <= nxt_armTwo;
      busy_ff    <= nxt_busy;
      convReq_ff <= nxt_convReq;
      ratio_ff   <= nxt_ratio;
      results_ff <= nxt_results;
      sampleSeen_ff <= nxt_sampleSeen;
    end
  end

  // ****************************************
  // Byte and serial read-out
  // ****************************************
  logic [7:0]   byteBus_ff;
  logic [7:0]   nxt_byteBus;
  logic         byteOe_ff;
  logic         nxt_byteOe;
  logic [3:0]   byteIdx_ff;   // Strobe count, 16 per full read
  logic [3:0]   nxt_byteIdx;
  logic         serA_ff;
  logic         nxt_serA;
  logic         serB_ff;
  logic         nxt_serB;
  logic         serOe_ff;
  logic         nxt_serOe;
  logic         mark_ff;
  logic         nxt_mark;
  logic         markOe_ff;
  logic         nxt_markOe;
  logic [3:0]   fallCnt_ff;   // Clock falls within the channel
  logic [3:0]   nxt_fallCnt;
  logic [2:0]   chan_ff;      // Channel on the primary line
  logic [2:0]   nxt_chan;
  result_word_t byteWord;
  result_word_t wordA;
  result_word_t wordB;
  logic [3:0]   bitSel;
  logic         curBitA;
  logic         curBitB;

  assign byteWord = results_ff[byteIdx_ff[3:1]];
  assign wordA    = results_ff[chan_ff];
  assign wordB    = results_ff[chan_ff ^ `ADC_GROUP_FLIP]; // [RL11]
  assign bitSel   = 4'hf - fallCnt_ff;
  assign curBitA  = wordA[bitSel];
  assign curBitB  = wordB[bitSel];

  // Next values of the read-out pins; results only change at load [RL15]
  always_comb begin
    nxt_byteBus = byteBus_ff;
    nxt_byteOe  = byteOe_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_serA    = serA_ff;
    nxt_serB    = serB_ff;
    nxt_serOe   = serOe_ff;
    nxt_mark    = mark_ff;
    nxt_markOe  = markOe_ff;
    nxt_fallCnt = fallCnt_ff;
    nxt_chan    = chan_ff;
    if (mode == MODE_BYTE) begin
      nxt_serOe = 1'b0;
      if (csRise) begin
        nxt_byteOe  = 1'b0;
        nxt_markOe  = 1'b0;                    // [RL5]
        nxt_byteIdx = '0;
      end else if (csFall) begin
        nxt_byteOe = 1'b1;                     // [RL4]
        nxt_markOe = 1'b1;
        nxt_mark   = 1'b0;
      end else if (csLow && rdFall) begin
        // Odd strobe count picks the second byte of the channel [RL3]
        nxt_byteBus = (byteIdx_ff[0] ^ sync2_ff[`PIN_ORDER]) ? byteWord[15:8] : byteWord[7:0];
        nxt_mark    = (byteIdx_ff < `ADC_MARK_STROBES); // [RL5]
        nxt_byteIdx = byteIdx_ff + 4'h1;       // [RL4]
      end
    end else if (mode == MODE_SERIAL) begin
      nxt_byteOe = 1'b0;
      if (!csLow) begin
        // Deselected: lines released, clock has no effect [RL7]
        nxt_serOe  = 1'b0;
        nxt_markOe = 1'b0;
      end else begin
        if (csFall || sclkRise) begin
          nxt_serA   = curBitA;                // [RL8] [RL9]
          nxt_serB   = curBitB;                // [RL11]
          nxt_serOe  = 1'b1;
          nxt_markOe = 1'b1;
          // Channel 5 leaves the secondary line at the same time [RL12] [RL13]
          nxt_mark   = (chan_ff == 3'h0);
        end
        if (sclkFall && !csFall) begin
          if (fallCnt_ff == SERIAL_FRAME - 4'h1) begin
            nxt_fallCnt = '0;                  // [RL23]
            nxt_chan    = chan_ff + 3'h1;      // [RL10]
            nxt_mark    = (chan_ff == 3'h7);   // [RL12]
          end else begin
            nxt_fallCnt = fallCnt_ff + 4'h1;   // [RL9]
          end
        end
      end
    end else begin
      // Word mode and the unused code drive nothing here [RL22]
      nxt_byteOe = 1'b0;
      nxt_serOe  = 1'b0;
      nxt_markOe = 1'b0;
    end
    if (state_ff == SEQ_LOAD) begin
      // Fresh results restart at channel 1
      nxt_chan    = '0;
      nxt_fallCnt = '0;
      nxt_byteIdx = '0;
    end
  end

  // Register stage of the read-out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byteBus_ff <= '0;
      byteOe_ff  <= 1'b0;
      byteIdx_ff <= '0;
      serA_ff    <= 1'b0;
      serB_ff    <= 1'b0;
      serOe_ff   <= 1'b0;
      mark_ff    <= 1'b0;
      markOe_ff  <= 1'b0;
      fallCnt_ff <= '0;
      chan_ff    <= '0;
    end else if (ce) begin
      byteBus_ff <= nxt_byteBus;
      byteOe_ff  <= nxt_byteOe;
      byteIdx_ff <= nxt_byteIdx;
      serA_ff    <= nxt_serA;
      serB_ff    <= nxt_serB;
      serOe_ff   <= nxt_serOe;
      mark_ff    <= nxt_mark;
      markOe_ff  <= nxt_markOe;
      fallCnt_ff <= nxt_fallCnt;
      chan_ff    <= nxt_chan;
    end
  end

  // Outputs straight from flops
  assign convReq              = convReq_ff;
  assign busy                 = busy_ff;
  assign byteOutputBus        = byteBus_ff;
  assign byteOutputBusOe      = byteOe_ff;
  assign serialOutPrimary     = serA_ff;
  assign serialOutSecondary   = serB_ff;
  assign serialOutOe          = serOe_ff;
  assign firstChannelMarker   = mark_ff;
  assign firstChannelMarkerOe = markOe_ff;
  assign oversampleRatio      = ratio_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_load_pad;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_ff == SEQ_LOAD) |=> results_ff[0] == {$past(avgBus.average[13:0]), 2'b00};
  endproperty
  a_load_pad: assert property (p_load_pad) else $error("result word not code plus zeros"); // [RL1]
  property p_byte_enable;
    @(posedge clk) disable iff (!rst_b)
      (mode == MODE_BYTE && csFall) |=> byteOe_ff && markOe_ff && !serOe_ff;
  endproperty
  a_byte_enable: assert property (p_byte_enable) else $error("byte bus not enabled"); // [RL4]
  property p_byte_first;
    @(posedge clk) disable iff (!rst_b)
      (mode == MODE_BYTE && csLow && rdFall && !csRise && byteIdx_ff == 4'h0 &&
       sync2_ff[`PIN_ORDER]) |=> byteBus_ff == $past(byteWord[15:8]) && mark_ff;
  endproperty
  a_byte_first: assert property (p_byte_first) else $error("upper byte not first"); // [RL3]
  property p_byte_mark_low;
    @(posedge clk) disable iff (!rst_b)
      (mode == MODE_BYTE && csLow && rdFall && !csRise && byteIdx_ff == 4'h2) |=> !mark_ff;
  endproperty
  a_byte_mark_low: assert property (p_byte_mark_low) else $error("marker high at third strobe"); // [RL5]
  property p_serial_idle;
    @(posedge clk) disable iff (!rst_b)
      (ce && mode == MODE_SERIAL && !csLow && state_ff != SEQ_LOAD)
        |=> !serOe_ff && !markOe_ff && $stable(fallCnt_ff);
  endproperty
  a_serial_idle: assert property (p_serial_idle) else $error("serial active while deselected"); // [RL7]
  property p_serial_msb;
    @(posedge clk) disable iff (!rst_b)
      (mode == MODE_SERIAL && csFall && fallCnt_ff == 4'h0 && state_ff != SEQ_LOAD)
        |=> serOe_ff && serA_ff == $past(wordA[15]) && serB_ff == $past(wordB[15]);
  endproperty
  a_serial_msb: assert property (p_serial_msb) else $error("MSB not driven at select"); // [RL8]
  property p_frame_wrap;
    @(posedge clk) disable iff (!rst_b)
      (mode == MODE_SERIAL && csLow && sclkFall && !csFall && state_ff != SEQ_LOAD &&
       fallCnt_ff == SERIAL_FRAME - 4'h1) |=> fallCnt_ff == 4'h0 && chan_ff == $past(chan_ff) + 3'h1;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("channel frame length wrong"); // [RL23]
  property p_ratio_latch;
    @(posedge clk) disable iff (!rst_b)
      $fell(busy_ff) |-> ratio_ff == (($past(osPins) > `ADC_OS_MAX_CODE) ? 3'h0 : $past(osPins));
  endproperty
  a_ratio_latch: assert property (p_ratio_latch) else $error("ratio not latched at busy fall"); // [RL17]
  property p_busy_hold;
    @(posedge clk) disable iff (!rst_b)
      (busy_ff && state_ff == SEQ_CONV) |=> $stable(results_ff[0]) && $stable(results_ff[7]);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("results changed while busy"); // [RL15]
  property p_busy_start;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_ff == SEQ_IDLE && nxt_state == SEQ_CONV) |=> busy_ff && convReq_ff;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised at start"); // [RL21]
endmodule
`default_nettype wire

/* File: verilog/sample_averager.sv */
// Averaging filter over power-of-two sample counts for all channels
`timescale 1ns/10ps
`default_nettype none
module sample_averager
  import adc_readout_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Sequencer side
  avg_if.avg        bus
);
  logic signed [`ADC_ACC_BITS-1:0] acc_ff  [`ADC_CHANNELS]; // Running sums
  logic signed [`ADC_ACC_BITS-1:0] nxt_acc [`ADC_CHANNELS];
  logic signed [`ADC_ACC_BITS-1:0] sumVal  [`ADC_CHANNELS]; // Sum with new sample
  logic signed [`ADC_ACC_BITS-1:0] shVal   [`ADC_CHANNELS]; // Sum divided down
  logic [6:0]                      cnt_ff;                  // Samples taken
  logic [6:0]                      nxt_cnt;
  logic [6:0]                      target;                  // Samples wanted
  logic                            done_ff;
  logic                            nxt_done;
  sample_bus_t                     avg_ff;
  sample_bus_t                     nxt_avg;

  assign bus.done    = done_ff;
  assign bus.average = avg_ff;

  // ****************************************
  // Accumulate and divide
  // ****************************************
  // Arithmetic shift keeps bipolar codes signed; truncates toward minus
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    nxt_avg  = avg_ff;
    target   = 7'h01 << bus.ratio; // [RL24]
    for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
      sumVal[ch] = acc_ff[ch] +
                   `ADC_ACC_BITS'($signed(bus.sample[ch*`ADC_CODE_BITS +: `ADC_CODE_BITS]));
      shVal[ch]  = sumVal[ch] >>> bus.ratio;
    end
    if (bus.clear) begin
      // Idle: nothing half-summed survives
      for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
        nxt_acc[ch] = '0;
      end
      nxt_cnt = '0;
    end else if (bus.sampleValid) begin
      if (cnt_ff + 7'h01 == target) begin
        // Last sample of the set: publish the mean [RL20]
        for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
          nxt_avg[ch*`ADC_CODE_BITS +: `ADC_CODE_BITS] = shVal[ch][`ADC_CODE_BITS-1:0];
          nxt_acc[ch] = '0;
        end
        nxt_cnt  = '0;
        nxt_done = 1'b1;
      end else begin
        for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
          nxt_acc[ch] = sumVal[ch];
        end
        nxt_cnt = cnt_ff + 7'h01;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int ch = 0; ch < `ADC_CHANNELS; ch++) begin
        acc_ff[ch] <= '0;
      end
      cnt_ff  <= '0;
      done_ff <= 1'b0;
      avg_ff  <= '0;
    end else if (bus.ce) begin
      acc_ff  <= nxt_acc;
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
      avg_ff  <= nxt_avg;
    end
  end

  // Done only after the wanted count of samples
  property p_done_count;
    @(posedge clk) disable iff (!rst_b)
      (bus.ce && bus.sampleValid && !bus.clear && (cnt_ff + 7'h01 != target)) |=> !done_ff;
  endproperty
  a_done_count: assert property (p_done_count) else $error("average published early"); // [RL24]
endmodule
`default_nettype wire
